/* dio_conditioner.sv */
// Discrete input qualification and discrete output drive, 32 pin slots.
// Assumes pins are asynchronous; configuration ports are steady on clk_sys_i.
`timescale 1ns/100ps

// What this block does
// - Each input yields a status output following its qualified on/off state.
// - Polarity: closed contact is ON when normal, OFF when inverted.
// - Entering ON waits the programmed delay in seconds before status shows ON.
// - Leaving ON before delay ends restarts qualification, no ON shown.
// - Input event selector none/rising/falling/both picks which status changes raise events.
// - Output polarity: energize on source ON when normal, on OFF when inverted, except a disabled source energizes only when claimed by time-proportioning output.
// - Output source is disabled, a discrete signal, or a constant level.
// - Output event selector; output events stored only when storage accepts events.
// - Output claimed by time-proportioning output follows only that function.
// - Channel split is 16 inputs/16 outputs or 8 inputs/24 outputs.
module dio_conditioner #(
  parameter int TICK_CYCLES = dio_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic split_sel_i,
  input wire logic [31:0] pin_in_i,
  input wire logic [31:0] in_invert_i,
  input wire logic [511:0] in_delay_s_i,
  input wire logic [63:0] in_evt_sel_i,
  input wire logic [31:0] out_invert_i,
  input wire logic [63:0] out_src_sel_i,
  input wire logic [31:0] out_src_sig_i,
  input wire logic [63:0] out_evt_sel_i,
  input wire logic store_events_i,
  input wire logic [31:0] tpo_claim_i,
  input wire logic [31:0] time_proportioning_output_i,
  output logic [31:0] input_channel_status_o,
  output logic [31:0] in_valid_o,
  output logic [31:0] in_event_o,
  output logic [31:0] out_drive_o,
  output logic [31:0] out_valid_o,
  output logic [31:0] out_event_o
);
  localparam int N = dio_pkg::TOTAL_CH;
  localparam int DW = dio_pkg::DLY_W;

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [dio_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic [N-1:0][DW-1:0] elapsed;
    logic [N-1:0] status;
    logic [N-1:0] in_evt;
    logic [N-1:0] drive;
    logic [N-1:0] out_evt;
  } dio_state_t;

  dio_state_t st_reg;
  dio_state_t st_next;
  logic [N-1:0] is_input;

  // ----------------------------------------------------------------
  // Channel split
  // ----------------------------------------------------------------
  // Low slots are inputs, the rest outputs; input count from the split select
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      is_input[i] = (split_sel_i == dio_pkg::SPLIT_8_24) ? (i < dio_pkg::SPLIT_B_IN)
                                                          : (i < dio_pkg::SPLIT_A_IN);
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process covers sync, tick divider, input qualify and output drive
  always_comb
  begin
    logic raw_on;
    logic src_on;
    logic new_drive;
    logic [1:0] esel;
    raw_on = 1'b0;
    src_on = 1'b0;
    new_drive = 1'b0;
    esel = 2'h0;
    st_next = st_reg;
    // Two stages before any logic reads a pin
    st_next.sync1 = pin_in_i;
    st_next.sync2 = st_reg.sync1;
    // One-second enable pulse
    st_next.tick = 1'b0;
    if (st_reg.tick_cnt == dio_pkg::TICK_W'(TICK_CYCLES - 1))
    begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end
    for (int i = 0; i < N; i++)
    begin
      st_next.in_evt[i] = 1'b0;
      st_next.out_evt[i] = 1'b0;
      if (is_input[i])
      begin
        st_next.drive[i] = 1'b0;
        raw_on = st_reg.sync2[i] ^ in_invert_i[i];
        esel = in_evt_sel_i[2*i +: 2];
        if (!raw_on)
        begin
          // Dropping out restarts qualification
          st_next.elapsed[i] = '0;
          st_next.status[i] = 1'b0;
        end
        else if (st_reg.elapsed[i] >= in_delay_s_i[DW*i +: DW])
        begin
          st_next.status[i] = 1'b1;
        end
        else if (st_reg.tick)
        begin
          st_next.elapsed[i] = st_reg.elapsed[i] + 1'b1;
        end
        if (st_next.status[i] != st_reg.status[i])
        begin
          st_next.in_evt[i] = st_next.status[i] ? esel[0] : esel[1];
        end
      end
      else
      begin
        st_next.status[i] = 1'b0;
        st_next.elapsed[i] = '0;
        case (dio_pkg::dio_src_t'(out_src_sel_i[2*i +: 2]))
          dio_pkg::SRC_OFF: src_on = 1'b0;
          dio_pkg::SRC_SIGNAL: src_on = out_src_sig_i[i];
          dio_pkg::SRC_CONST0: src_on = 1'b0;
          dio_pkg::SRC_CONST1: src_on = 1'b1;
          default: src_on = 1'b0;
        endcase
        // Disabled source keeps the load off regardless of polarity
        if (out_src_sel_i[2*i +: 2] == dio_pkg::SRC_OFF)
          new_drive = 1'b0;
        else
          new_drive = src_on ^ out_invert_i[i];
        if (tpo_claim_i[i])
          new_drive = time_proportioning_output_i[i];
        st_next.drive[i] = new_drive;
        esel = out_evt_sel_i[2*i +: 2];
        if (new_drive != st_reg.drive[i] && store_events_i)
        begin
          st_next.out_evt[i] = new_drive ? esel[0] : esel[1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // Outputs straight from flops; valid masks follow the split
  assign input_channel_status_o = st_reg.status;
  assign in_event_o = st_reg.in_evt;
  assign out_drive_o = st_reg.drive;
  assign out_event_o = st_reg.out_evt;
  assign in_valid_o = is_input;
  assign out_valid_o = ~is_input;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_status_needs_raw: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (is_input[0] && $stable(split_sel_i) && (st_reg.sync2[0] ^ in_invert_i[0]) == 1'b0)
      |=> !st_reg.status[0])
    else $error("status stayed on with raw input off");
  chk_zero_delay_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (is_input[0] && in_delay_s_i[DW-1:0] == '0 && (st_reg.sync2[0] ^ in_invert_i[0]) && $stable(split_sel_i))
      |=> st_reg.status[0])
    else $error("zero delay did not pass through");
  chk_status_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(st_reg.status[0]) |-> st_reg.elapsed[0] >= in_delay_s_i[DW-1:0])
    else $error("status rose before delay");
  chk_rise_event: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (st_reg.in_evt[0]) |-> ($past(in_evt_sel_i[1:0]) != dio_pkg::EVT_NONE))
    else $error("input event with selector none");
  chk_tpo_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!is_input[N-1] && tpo_claim_i[N-1]) |=> st_reg.drive[N-1] == $past(time_proportioning_output_i[N-1]))
    else $error("claimed output not driven by time proportioning");
  chk_out_event_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    st_reg.out_evt[N-1] |-> $past(store_events_i))
    else $error("output event without storage enabled");
  chk_out_polarity: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!is_input[N-1] && !tpo_claim_i[N-1] && out_src_sel_i[2*N-1 -: 2] == dio_pkg::SRC_CONST1)
      |=> st_reg.drive[N-1] == !$past(out_invert_i[N-1]))
    else $error("output polarity wrong");
  chk_split_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (split_sel_i == dio_pkg::SPLIT_8_24) |-> (in_valid_o == 32'h0000_00FF))
    else $error("split mask wrong");

  // Slot 0 is an input and slot 31 an output under either split, so both are always watchable
  chk_fall_event: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($fell(st_reg.status[0]) && $past(in_evt_sel_i[1]))
      |-> st_reg.in_evt[0])
    else $error("falling status gave no event");
  chk_src_off_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!is_input[N-1] && !tpo_claim_i[N-1] && out_src_sel_i[2*N-1 -: 2] == dio_pkg::SRC_OFF)
      |=> !st_reg.drive[N-1])
    else $error("disabled output still driven");
  // Drive is judged against the split seen when it was computed
  chk_input_no_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    1'b1
      |=> ((st_reg.drive & $past(is_input)) == '0))
    else $error("input slot drives a load");
endmodule : dio_conditioner

/* dio_field_model.sv */
// Field side model: dry contacts into the input pins, relay loads on the outputs.
// Assumes the conditioner drives loads with a plain high-is-energized level.
`timescale 1ns/100ps
module dio_field_model (
  input wire logic [31:0] contact_i,
  input wire logic [31:0] drive_i,
  output logic [31:0] pin_o,
  output logic [31:0] energized_o
);
  // Contacts are hard wired, so a closed contact reads 1 with no bounce
  assign pin_o = contact_i;
  // Load follows its drive line; no coil latency modelled
  assign energized_o = drive_i;
endmodule : dio_field_model

/* dio_pkg.sv */
// Package for the discrete input/output conditioner.
// Assumes a single 50 MHz system clock; all users name items as dio_pkg::name.
package dio_pkg;
  // ----------------------------------------------------------------
  // Channel counts and timing
  // ----------------------------------------------------------------
  localparam int TOTAL_CH = 32;
  localparam int SPLIT_A_IN = 16;
  localparam int SPLIT_B_IN = 8;
  localparam int DLY_W = 16;
  localparam int CLK_HZ = 50000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int TICK_W = 26;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EVT_NONE = 2'h0,
    EVT_RISE = 2'h1,
    EVT_FALL = 2'h2,
    EVT_BOTH = 2'h3
  } dio_evt_t;
  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_SIGNAL = 2'h1,
    SRC_CONST0 = 2'h2,
    SRC_CONST1 = 2'h3
  } dio_src_t;
  localparam logic SPLIT_16_16 = 1'h0;
  localparam logic SPLIT_8_24 = 1'h1;
endpackage : dio_pkg

/* testbench.sv */
// Directed bench for the discrete input/output conditioner.
// Assumes a 4-cycle tick so that delays of a few seconds stay short.
`timescale 1ns/100ps
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic split_sel_i = 1'b0, store_events_i = 1'b0, ev_clr = 1'b0;
  logic [31:0] contact = '0, in_invert_i = '0, out_invert_i = '0, out_src_sig_i = '0, tpo_claim_i = '0, tpo = '0;
  logic [511:0] in_delay_s_i = '0;
  logic [63:0] in_evt_sel_i = '0, out_src_sel_i = '0, out_evt_sel_i = '0;
  logic [31:0] pin, status, in_valid, in_ev, drive, out_valid, out_ev, load, iev = '0, oev = '0;
  int mismatches = 0;
  int cmp_count = 0;
  // ----------------------------------------
  // Clock, sticky event catchers, instances
  // ----------------------------------------
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    iev <= ev_clr ? '0 : (iev | in_ev);
    oev <= ev_clr ? '0 : (oev | out_ev);
  end
  dio_field_model u_field (.contact_i(contact), .drive_i(drive), .pin_o(pin), .energized_o(load));
  dio_conditioner #(.TICK_CYCLES(4)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .split_sel_i(split_sel_i),
    .pin_in_i(pin), .in_invert_i(in_invert_i), .in_delay_s_i(in_delay_s_i), .in_evt_sel_i(in_evt_sel_i),
    .out_invert_i(out_invert_i), .out_src_sel_i(out_src_sel_i), .out_src_sig_i(out_src_sig_i),
    .out_evt_sel_i(out_evt_sel_i), .store_events_i(store_events_i), .tpo_claim_i(tpo_claim_i),
    .time_proportioning_output_i(tpo), .input_channel_status_o(status), .in_valid_o(in_valid),
    .in_event_o(in_ev), .out_drive_o(drive), .out_valid_o(out_valid), .out_event_o(out_ev));
  // Inputs change on the falling edge only
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One cycle clear; an event in that cycle is lost, so clear before stimulus
  task automatic clr;
    ev_clr = 1'b1;
    cyc(1);
    ev_clr = 1'b0;
  endtask : clr
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the 121 cycles the tests need
  initial
  begin
    #20000;
    mismatches++;
    finish_test();
  end
  initial
  begin
    cyc(2);
    rst_i = 1'b0;
    chk("status rst", '0, status);
    chk("drive rst", '0, drive);
    chk("in mask", 32'h0000FFFF, in_valid);
    chk("out mask", 32'hFFFF0000, out_valid);
    split_sel_i = 1'b1;
    out_src_sel_i[17:16] = 2'h3;
    cyc(3);
    chk("in mask b", 32'h000000FF, in_valid);
    chk("drive b", 32'h00000100, drive);
    split_sel_i = 1'b0;
    cyc(3);
    chk("drive a", '0, drive);
    out_src_sel_i[17:16] = 2'h0;
    $display("test split done");
    for (int s = 0; s < 4; s++)
    begin
      in_evt_sel_i[1:0] = s[1:0];
      clr();
      contact[0] = 1'b1;
      cyc(2);
      chk("status early", '0, status);
      cyc(1);
      chk("status on", 32'h1, status);
      cyc(2);
      chk("rise event", {31'h0, s[0]}, iev);
      clr();
      contact[0] = 1'b0;
      cyc(5);
      chk("status off", '0, status);
      chk("fall event", {31'h0, s[1]}, iev);
    end
    in_invert_i[1] = 1'b1;
    cyc(5);
    chk("invert open", 32'h2, status);
    contact[1] = 1'b1;
    cyc(5);
    chk("invert closed", '0, status);
    $display("test input done");
    in_delay_s_i[15:0] = 16'h0003;
    contact[0] = 1'b1;
    cyc(6);
    chk("delay early", '0, status);
    contact[0] = 1'b0;
    cyc(2);
    contact[0] = 1'b1;
    cyc(6);
    chk("delay restart", '0, status);
    cyc(14);
    chk("delay done", 32'h1, status);
    $display("test delay done");
    out_src_sel_i[37:32] = 6'h2D;
    out_src_sig_i[16] = 1'b1;
    out_invert_i[20:18] = 3'h7;
    tpo_claim_i[20] = 1'b1;
    tpo[20] = 1'b1;
    cyc(3);
    chk("drive src", 32'h00170000, drive);
    chk("load", 32'h00170000, load);
    out_evt_sel_i[33:32] = 2'h3;
    clr();
    out_invert_i[16] = 1'b1;
    cyc(3);
    chk("drive inv", 32'h00160000, drive);
    chk("out event gated", '0, oev);
    store_events_i = 1'b1;
    out_invert_i[16] = 1'b0;
    cyc(3);
    chk("out event", 32'h00010000, oev);
    tpo[20] = 1'b0;
    cyc(3);
    chk("drive claim", 32'h00070000, drive);
    // Top slot exercises the slot-31 checks: constant source, polarity, falling event, claim, gating
    clr();
    out_evt_sel_i[63:62] = 2'h2;
    out_src_sel_i[63:62] = 2'h3;
    cyc(3);
    chk("drive top", 32'h80070000, drive);
    chk("top rise ignored", '0, oev);
    out_invert_i[31] = 1'b1;
    cyc(3);
    chk("drive top inv", 32'h00070000, drive);
    chk("top fall event", 32'h80000000, oev);
    tpo_claim_i[31] = 1'b1;
    tpo[31] = 1'b1;
    cyc(3);
    chk("drive top claim", 32'h80070000, drive);
    clr();
    store_events_i = 1'b0;
    tpo[31] = 1'b0;
    cyc(3);
    chk("drive top release", 32'h00070000, drive);
    chk("top event gated", '0, oev);
    $display("test output done");
    finish_test();
  end
endmodule : testbench
